// ==== hw/flg_defines.svh ====
// Purpose: command codes, field positions, reset values for the fault latch and pin control block
// Assumes: 16-bit command registers reached through a decoded command port
// Notes: definitions only
//
// Overview of operation
// [R01] summary bit zero set when any latched
// [R02] fourteen latched bits in fixed channel order
// [R03] enabled instantaneous fault sets and holds latch
// [R04] clearing enable clears latched bit immediately
// [R05] reading latched register clears; faults re-set
// [R06] pin0 mode 00 carries power-good
// [R07] pin0 mode 01 carries inverted power-good
// [R08] pin0 mode 10 open-drain follows written bit
// [R09] pin0 mode 11 input, bit reads pin
// [R10] pin1 modes 00/01 carry DAC-fault flag
// [R11] pin1 mode 10 output, 11 input
// [R12] strap high at reset clears pin bits
// [R13] alert pin level readable, read-only
// [R14] alert disable blocks alert; else low on fault
// [R15] test bit freezes converter, host writes results
// [R16] strap status bit shows strap pin level
// [R17] track-start bit only on tracking variant
// [R18] monitor mask bits 0-6 select channels
// [R19] disabled fault keeps latched bit zero
// [R20] reserved bits read zero, writes ignored
// [R21] read captures value; same-cycle fault stays
`ifndef FLG_DEFINES_SVH
`define FLG_DEFINES_SVH

// command codes
`define FLG_CMD_INST_FAULT 8'h10
`define FLG_CMD_FAULT_EN 8'h11
`define FLG_CMD_SUMMARY 8'h12
`define FLG_CMD_LATCHED 8'h13
`define FLG_CMD_PIN_CTRL 8'h14
`define FLG_CMD_MON_MASK 8'h15

// pin and general control field positions
`define FLG_PIN0_SEL_LSB 0
`define FLG_PIN1_SEL_LSB 2
`define FLG_PIN0_VALUE_BIT 4
`define FLG_PIN1_VALUE_BIT 5
`define FLG_ALERT_LEVEL_BIT 6
`define FLG_ALERT_DISABLE_BIT 7
`define FLG_RESULT_WRITE_TEST_BIT 8
`define FLG_STRAP_LEVEL_BIT 9
`define FLG_BEGIN_TRACKING_BIT 10
`define FLG_SUMMARY_BIT 0

// fault bit positions
`define FLG_F_CH0A_OV 0
`define FLG_F_CH0A_UV 1
`define FLG_F_CH0A_DAC 2
`define FLG_F_CH0B_OV 3
`define FLG_F_CH0B_UV 4
`define FLG_F_CH1A_OV 5
`define FLG_F_CH1A_UV 6
`define FLG_F_CH1A_DAC 7
`define FLG_F_CH1B_OV 8
`define FLG_F_CH1B_UV 9
`define FLG_F_CORE_OV 10
`define FLG_F_CORE_UV 11
`define FLG_F_V12_OV 12
`define FLG_F_V12_UV 13
`define FLG_FAULT_COUNT 14
`define FLG_MASK_COUNT 7

// over/under-voltage bits only (DAC bits excluded) for power-good
`define FLG_VOLT_FAULT_MASK 14'h3F7B

// reset values
`define FLG_RST_FAULT_EN 14'h0000
`define FLG_RST_PIN_SEL 2'h2
`define FLG_RST_PIN_VALUE 1'h1
`define FLG_RST_ALERT_DISABLE 1'h1
`define FLG_RST_RESULT_WRITE_TEST 1'h0
`define FLG_RST_MON_MASK 7'h00

// DAC fault codes
`define FLG_DAC_LOW 8'h00
`define FLG_DAC_HIGH 8'hFF

`endif

// ==== hw/flg_fault_latch.sv ====
// Purpose: per-bit sticky fault latches with enable gating and read clear
// Assumes: instantaneous faults synchronous to sys_clk
// Notes: a fault present in the clearing cycle stays latched
`timescale 1ns/1ps
module flg_fault_latch #(
  parameter int WIDTH = 14
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] instFault,
  input wire logic [WIDTH-1:0] faultEnable,
  input wire logic clearAll,
  output logic [WIDTH-1:0] latched
);

  flg_pkg::flg_latch_t state;
  flg_pkg::flg_latch_t next_state;
  logic [WIDTH-1:0] next_bits;

  // per-bit latch update
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // [R03] [R04] [R19] set, hold, enable gate
      // [R05] [R21] read clear, set wins
      assign next_bits[i] = faultEnable[i] & (instFault[i] | (state.latched[i] & ~clearAll));
    end
  endgenerate

  // next state
  always_comb begin
    next_state = state;
    next_state.latched = next_bits;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign latched = state.latched;

endmodule // flg_fault_latch

// ==== hw/flg_fault_latch_gpio_control.sv ====
// Purpose: latched fault, summary, pin control and converter mask command registers
// Assumes: command port already decoded from the serial protocol; inputs synchronous to sys_clk
// Notes: read data appears one cycle after the read strobe; pins are open-drain, drive low only
`timescale 1ns/1ps
`include "flg_defines.svh"
module flg_fault_latch_gpio_control #(
  parameter bit TRACK_VARIANT = 1'b0,
  parameter int FAULT_COUNT = `FLG_FAULT_COUNT,
  parameter int MASK_COUNT = `FLG_MASK_COUNT
) (
  input wire logic sys_clk,
  input wire logic rstn,
  // command port
  input wire logic [7:0] cmdCode,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [15:0] cmdWriteData,
  output logic [15:0] cmdReadData,
  output logic cmdReadValid,
  // fault sources
  input wire logic [FAULT_COUNT-1:0] instFault,
  input wire logic [7:0] dac0Code,
  input wire logic [7:0] dac1Code,
  // general pins
  input wire logic gpio0In,
  output logic gpio0Out,
  output logic gpio0OeN,
  input wire logic gpio1In,
  output logic gpio1Out,
  output logic gpio1OeN,
  // alert pin, active low open-drain
  input wire logic alertIn,
  output logic alertOut,
  output logic alertOeN,
  // strap pin
  input wire logic strapIn,
  // converter and tracking control
  output logic [MASK_COUNT-1:0] monitorMask,
  output logic hostResultWriteTest,
  output logic trackStart,
  input wire logic trackDone
);

  flg_pkg::flg_ctrl_t state;
  flg_pkg::flg_ctrl_t next_state;
  logic [FAULT_COUNT-1:0] latched;
  logic readLatched;
  logic anyLatched;
  logic powerGood;
  logic dacFault;
  logic pin0Level;
  logic pin1Level;
  logic [15:0] summaryWord;
  logic [15:0] latchedWord;
  logic [15:0] instWord;
  logic [15:0] enableWord;
  logic [15:0] pinWord;
  logic [15:0] maskWord;

  // read of the latched register clears the latches at the same edge
  assign readLatched = cmdRead && (cmdCode == `FLG_CMD_LATCHED);

  // sticky fault bank; sees the enable being written, so a cleared enable drops its latch at the write edge
  flg_fault_latch #(
    .WIDTH(FAULT_COUNT)
  ) u_latch (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .instFault(instFault),
    .faultEnable(next_state.faultEnable),
    .clearAll(readLatched),
    .latched(latched)
  );

  // status terms
  // [R01] any latched bit
  assign anyLatched = |latched;
  // [R06] no over or under voltage
  assign powerGood = ~|(instFault & `FLG_VOLT_FAULT_MASK);
  // [R10] dac code at a rail
  assign dacFault = (dac0Code == `FLG_DAC_LOW) || (dac0Code == `FLG_DAC_HIGH) ||
                    (dac1Code == `FLG_DAC_LOW) || (dac1Code == `FLG_DAC_HIGH);

  // pin 0 value as seen by pin and register bit
  always_comb begin
    case (state.pin0Sel)
      // [R06] power-good mode
      flg_pkg::FLG_PIN_STATUS: begin
        pin0Level = powerGood;
      end
      // [R07] inverted power-good
      flg_pkg::FLG_PIN_STATUS_INV: begin
        pin0Level = ~powerGood;
      end
      // [R08] written value
      flg_pkg::FLG_PIN_OUTPUT: begin
        pin0Level = state.pin0Value;
      end
      // [R09] input readback
      flg_pkg::FLG_PIN_INPUT: begin
        pin0Level = gpio0In;
      end
      default: begin
        pin0Level = state.pin0Value;
      end
    endcase
  end

  // pin 1 value as seen by pin and register bit
  always_comb begin
    case (state.pin1Sel)
      // [R10] dac fault flag
      flg_pkg::FLG_PIN_STATUS: begin
        pin1Level = dacFault;
      end
      // [R10] inverted dac fault
      flg_pkg::FLG_PIN_STATUS_INV: begin
        pin1Level = ~dacFault;
      end
      // [R11] written value
      flg_pkg::FLG_PIN_OUTPUT: begin
        pin1Level = state.pin1Value;
      end
      // [R11] input readback
      flg_pkg::FLG_PIN_INPUT: begin
        pin1Level = gpio1In;
      end
      default: begin
        pin1Level = state.pin1Value;
      end
    endcase
  end

  // register read words, reserved bits zero
  always_comb begin
    // [R20] reserved bits zero
    summaryWord = 16'h0000;
    latchedWord = 16'h0000;
    instWord = 16'h0000;
    enableWord = 16'h0000;
    pinWord = 16'h0000;
    maskWord = 16'h0000;
    // [R01] summary without clearing
    summaryWord[`FLG_SUMMARY_BIT] = anyLatched;
    // [R02] latched bit order
    latchedWord[FAULT_COUNT-1:0] = latched;
    instWord[FAULT_COUNT-1:0] = instFault;
    enableWord[FAULT_COUNT-1:0] = state.faultEnable;
    pinWord[`FLG_PIN0_SEL_LSB +: 2] = state.pin0Sel;
    pinWord[`FLG_PIN1_SEL_LSB +: 2] = state.pin1Sel;
    pinWord[`FLG_PIN0_VALUE_BIT] = pin0Level;
    pinWord[`FLG_PIN1_VALUE_BIT] = pin1Level;
    // [R13] alert pin level
    pinWord[`FLG_ALERT_LEVEL_BIT] = alertIn;
    pinWord[`FLG_ALERT_DISABLE_BIT] = state.alertDisable;
    pinWord[`FLG_RESULT_WRITE_TEST_BIT] = state.resultWriteTest;
    // [R16] strap level
    pinWord[`FLG_STRAP_LEVEL_BIT] = strapIn;
    // [R17] pending only on tracking variant
    pinWord[`FLG_BEGIN_TRACKING_BIT] = TRACK_VARIANT & state.trackPending;
    // [R18] monitor mask bits
    maskWord[MASK_COUNT-1:0] = state.monitorMask;
  end

  // next state: writes, reads, pins
  always_comb begin
    next_state = state;
    next_state.readValid = 1'b0;
    next_state.trackStartPulse = 1'b0;
    // writes
    if (cmdWrite) begin
      case (cmdCode)
        `FLG_CMD_FAULT_EN: begin
          // [R04] enable clear drops latch
          next_state.faultEnable = cmdWriteData[FAULT_COUNT-1:0];
        end
        `FLG_CMD_PIN_CTRL: begin
          next_state.pin0Sel = flg_pkg::flg_pin_mode_t'(cmdWriteData[`FLG_PIN0_SEL_LSB +: 2]);
          next_state.pin1Sel = flg_pkg::flg_pin_mode_t'(cmdWriteData[`FLG_PIN1_SEL_LSB +: 2]);
          next_state.pin0Value = cmdWriteData[`FLG_PIN0_VALUE_BIT];
          next_state.pin1Value = cmdWriteData[`FLG_PIN1_VALUE_BIT];
          next_state.alertDisable = cmdWriteData[`FLG_ALERT_DISABLE_BIT];
          // [R15] test mode select
          next_state.resultWriteTest = cmdWriteData[`FLG_RESULT_WRITE_TEST_BIT];
          // [R17] start tracking
          if (TRACK_VARIANT && cmdWriteData[`FLG_BEGIN_TRACKING_BIT]) begin
            next_state.trackPending = 1'b1;
            next_state.trackStartPulse = 1'b1;
          end
        end
        `FLG_CMD_MON_MASK: begin
          // [R18] mask write
          next_state.monitorMask = cmdWriteData[MASK_COUNT-1:0];
        end
        default: begin
          // [R20] read-only or unmapped, ignored
          next_state.monitorMask = state.monitorMask;
        end
      endcase
    end
    // tracking done clears pending unless a new start arrives
    if (trackDone && !next_state.trackStartPulse) begin
      next_state.trackPending = 1'b0;
    end
    // [R12] strap caught at first edge after reset
    if (!state.strapDone) begin
      next_state.strapDone = 1'b1;
      if (strapIn) begin
        next_state.pin0Value = 1'b0;
        next_state.pin1Value = 1'b0;
      end
    end
    // reads, value captured before the clear
    if (cmdRead) begin
      next_state.readValid = 1'b1;
      case (cmdCode)
        `FLG_CMD_INST_FAULT: begin
          next_state.readData = instWord;
        end
        `FLG_CMD_FAULT_EN: begin
          next_state.readData = enableWord;
        end
        `FLG_CMD_SUMMARY: begin
          next_state.readData = summaryWord;
        end
        // [R21] capture then clear
        `FLG_CMD_LATCHED: begin
          next_state.readData = latchedWord;
        end
        `FLG_CMD_PIN_CTRL: begin
          next_state.readData = pinWord;
        end
        `FLG_CMD_MON_MASK: begin
          next_state.readData = maskWord;
        end
        default: begin
          next_state.readData = 16'h0000;
        end
      endcase
    end
    // pins drive low when their value is low, except input mode
    // [R08] [R09] open-drain pin 0
    next_state.gpio0OeN = (state.pin0Sel == flg_pkg::FLG_PIN_INPUT) | pin0Level;
    // [R11] open-drain pin 1
    next_state.gpio1OeN = (state.pin1Sel == flg_pkg::FLG_PIN_INPUT) | pin1Level;
    // [R14] alert gated by disable
    next_state.alertOeN = state.alertDisable | ~anyLatched;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.faultEnable <= `FLG_RST_FAULT_EN;
      state.pin0Sel <= flg_pkg::flg_pin_mode_t'(`FLG_RST_PIN_SEL);
      state.pin1Sel <= flg_pkg::flg_pin_mode_t'(`FLG_RST_PIN_SEL);
      state.pin0Value <= `FLG_RST_PIN_VALUE;
      state.pin1Value <= `FLG_RST_PIN_VALUE;
      state.alertDisable <= `FLG_RST_ALERT_DISABLE;
      state.resultWriteTest <= `FLG_RST_RESULT_WRITE_TEST;
      state.monitorMask <= `FLG_RST_MON_MASK;
      state.gpio0OeN <= 1'b1;
      state.gpio1OeN <= 1'b1;
      state.alertOeN <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign cmdReadData = state.readData;
  assign cmdReadValid = state.readValid;
  assign gpio0Out = 1'b0;
  assign gpio1Out = 1'b0;
  assign alertOut = 1'b0;
  assign gpio0OeN = state.gpio0OeN;
  assign gpio1OeN = state.gpio1OeN;
  assign alertOeN = state.alertOeN;
  assign monitorMask = state.monitorMask;
  // [R15] freezes converter result updates
  assign hostResultWriteTest = state.resultWriteTest;
  assign trackStart = state.trackStartPulse;

endmodule // flg_fault_latch_gpio_control

// ==== hw/flg_pkg.sv ====
// Purpose: types for the fault latch and pin control block
// Assumes: constants live in flg_defines.svh
// Notes: pin function codes are the two-bit select field values
package flg_pkg;

  typedef enum logic [1:0] {
    FLG_PIN_STATUS = 2'h0,
    FLG_PIN_STATUS_INV = 2'h1,
    FLG_PIN_OUTPUT = 2'h2,
    FLG_PIN_INPUT = 2'h3
  } flg_pin_mode_t;

  typedef struct packed {
    logic [13:0] faultEnable;
    flg_pin_mode_t pin0Sel;
    flg_pin_mode_t pin1Sel;
    logic pin0Value;
    logic pin1Value;
    logic alertDisable;
    logic resultWriteTest;
    logic trackPending;
    logic trackStartPulse;
    logic [6:0] monitorMask;
    logic strapDone;
    logic [15:0] readData;
    logic readValid;
    logic gpio0OeN;
    logic gpio1OeN;
    logic alertOeN;
  } flg_ctrl_t;

  typedef struct packed {
    logic [13:0] latched;
  } flg_latch_t;

endpackage

// ==== sim/flg_checker_asserts.sv ====
// Purpose: port-level checks of the fault latch and pin control block
// Assumes: one clock domain, rstn asynchronous active low
// Notes: bound to the design top from the testbench file
`timescale 1ns/1ps
module flg_checker #(
  parameter bit TRACK_VARIANT = 1'b0,
  parameter int FAULT_COUNT = 14,
  parameter int MASK_COUNT = 7
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] cmdCode,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [15:0] cmdWriteData,
  input wire logic [15:0] cmdReadData,
  input wire logic cmdReadValid,
  input wire logic gpio0Out,
  input wire logic gpio1Out,
  input wire logic alertIn,
  input wire logic alertOut,
  input wire logic strapIn,
  input wire logic [MASK_COUNT-1:0] monitorMask,
  input wire logic hostResultWriteTest,
  input wire logic trackStart
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // open-drain pin outputs, and reads of the summary, latched, pin control, mask and unmapped registers and what they must return
  property p_summary_reserved;
    cmdRead && cmdCode == 8'h12 |=> cmdReadValid && cmdReadData[15:1] == 15'h0000;
  endproperty
  a_summary_reserved: assert property (p_summary_reserved)
    else $error("summary read has upper bits set");
  property p_latched_reserved;
    cmdRead && cmdCode == 8'h13 |=> cmdReadData[15:14] == 2'h0;
  endproperty
  a_latched_reserved: assert property (p_latched_reserved)
    else $error("latched read has bits 15:14 set");
  property p_disabled_zero;
    cmdWrite && cmdCode == 8'h11 ##1 !cmdWrite ##1 cmdRead && cmdCode == 8'h13 && !cmdWrite
      |=> (cmdReadData[13:0] & ~$past(cmdWriteData[13:0], 3)) == 14'h0000;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("latched bit set while its enable is off");
  property p_open_drain;
    gpio0Out == 1'b0 && gpio1Out == 1'b0 && alertOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven high");
  property p_alert_bit;
    cmdRead && cmdCode == 8'h14 |=> cmdReadData[6] == $past(alertIn);
  endproperty
  a_alert_bit: assert property (p_alert_bit)
    else $error("alert level bit differs from pin");
  property p_test_bit;
    cmdRead && cmdCode == 8'h14 |=> cmdReadData[8] == $past(hostResultWriteTest);
  endproperty
  a_test_bit: assert property (p_test_bit)
    else $error("test bit read differs from output");
  property p_strap_bit;
    cmdRead && cmdCode == 8'h14 |=> cmdReadData[9] == $past(strapIn);
  endproperty
  a_strap_bit: assert property (p_strap_bit)
    else $error("strap bit differs from strap pin");
  property p_track_base;
    !TRACK_VARIANT && cmdRead && cmdCode == 8'h14 |=> cmdReadData[10] == 1'b0 && !trackStart;
  endproperty
  a_track_base: assert property (p_track_base)
    else $error("tracking active on base variant");
  property p_mask_read;
    cmdRead && cmdCode == 8'h15 |=> cmdReadData[6:0] == $past(monitorMask) && cmdReadData[15:7] == 9'h000;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read differs from mask output");
  property p_pin_reserved;
    cmdRead && cmdCode == 8'h14 |=> cmdReadData[15:11] == 5'h00;
  endproperty
  a_pin_reserved: assert property (p_pin_reserved)
    else $error("pin control reserved bits set");
  property p_unmapped;
    cmdRead && (cmdCode < 8'h10 || cmdCode > 8'h15) |=> cmdReadValid && cmdReadData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // flg_checker

// ==== sim/flg_host_model.sv ====
// Purpose: host side of the decoded command port
// Assumes: commands taken on the rising edge with the strobe high
// Notes: one command at a time, lines scrambled when idle
`timescale 1ns/1ps
module flg_host_model (
  input wire logic sys_clk,
  output logic [7:0] cmdCode,
  output logic cmdWrite,
  output logic cmdRead,
  output logic [15:0] cmdWriteData
);
  // idle port at time zero
  initial begin
    cmdCode = 8'h00;
    cmdWrite = 1'b0;
    cmdRead = 1'b0;
    cmdWriteData = 16'h0000;
  end
  // raise after an edge, hold over the taking edge, then release
  task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    cmdCode = c;
    cmdWrite = w;
    cmdRead = !w;
    cmdWriteData = d;
    @(posedge sys_clk);
    #1;
    cmdWrite = 1'b0;
    cmdRead = 1'b0;
    cmdCode = ~c; // stale code must not be relied on
    cmdWriteData = ~d;
  endtask
endmodule // flg_host_model

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the fault latch and pin control block
// Assumes: pins pulled up, an outside driver may pull a pin low
// Notes: read results matched oldest first from a queue
`timescale 1ns/1ps
`include "flg_defines.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] cmdCode;
  logic cmdWrite, cmdRead;
  logic [15:0] cmdWriteData, cmdReadData;
  logic cmdReadValid;
  logic [13:0] instFault = 14'h0000;
  logic [7:0] dac0Code = 8'h80;
  logic [7:0] dac1Code = 8'h80;
  logic ext0 = 1'b1;
  logic ext1 = 1'b1;
  logic strapIn = 1'b0;
  logic gpio0Out, gpio0OeN, gpio1Out, gpio1OeN, alertOut, alertOeN, hostResultWriteTest, trackStart;
  logic [6:0] monitorMask;
  int failCount = 0;
  int nCompared = 0;
  logic [15:0] expQ[$];
  logic [15:0] w;
  logic [13:0] en, f;
  logic pg, df, b0, b1;
  // wire levels from pull-ups and enables
  wire gpio0Pin = gpio0OeN ? ext0 : 1'b0;
  wire gpio1Pin = gpio1OeN ? ext1 : 1'b0;
  wire alertPin = alertOeN;

  always #2.5 sys_clk = ~sys_clk;

  flg_fault_latch_gpio_control flg_fault_latch_gpio_control_i (.sys_clk, .rstn, .cmdCode, .cmdWrite,
    .cmdRead, .cmdWriteData, .cmdReadData, .cmdReadValid, .instFault, .dac0Code, .dac1Code,
    .gpio0In(gpio0Pin), .gpio0Out, .gpio0OeN, .gpio1In(gpio1Pin), .gpio1Out, .gpio1OeN,
    .alertIn(alertPin), .alertOut, .alertOeN, .strapIn, .monitorMask, .hostResultWriteTest,
    .trackStart, .trackDone(1'b0));
  flg_host_model flg_host_model_i (.sys_clk, .cmdCode, .cmdWrite, .cmdRead, .cmdWriteData);

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    flg_host_model_i.issue(1'b1, c, d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    expQ.push_back(e);
    flg_host_model_i.issue(1'b0, c, 16'h0000);
  endtask
  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    #1;
    strapIn = s;
    rstn = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
  endtask
  task automatic pulse(input logic [13:0] v);
    @(posedge sys_clk);
    #1;
    instFault = v;
    @(posedge sys_clk);
    #1;
    instFault = 14'h0000;
  endtask
  task automatic giveVerdict;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // read results against the oldest note
  always @(negedge sys_clk) begin
    if (cmdReadValid === 1'b1) cmp("read data", (expQ.size() > 0) ? expQ.pop_front() : 16'hDEAD, cmdReadData);
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #40000;
    failCount++;
    giveVerdict();
  end

  // main sequence
  initial begin
    void'($urandom(24));
    do_reset(1'b0);
    rd(`FLG_CMD_PIN_CTRL, 16'h00FA);
    rd(`FLG_CMD_MON_MASK, 16'h0000);
    rd(`FLG_CMD_LATCHED, 16'h0000);
    rd(8'h77, 16'h0000);
    repeat (10) begin
      en = 14'($urandom);
      f = 14'($urandom);
      w = 16'($urandom);
      wr(`FLG_CMD_MON_MASK, w);
      rd(`FLG_CMD_MON_MASK, w & 16'h007F);
      cmp("monitor mask", {9'h000, w[6:0]}, {9'h000, monitorMask});
      wr(`FLG_CMD_FAULT_EN, {2'b11, en});
      rd(`FLG_CMD_FAULT_EN, {2'b00, en});
      pulse(f);
      rd(`FLG_CMD_SUMMARY, {15'h0000, |(en & f)});
      rd(`FLG_CMD_SUMMARY, {15'h0000, |(en & f)});
      rd(`FLG_CMD_LATCHED, {2'b00, en & f});
      rd(`FLG_CMD_LATCHED, 16'h0000);
    end
    wr(`FLG_CMD_FAULT_EN, 16'h3FFF);
    instFault = 14'h0810;
    rd(`FLG_CMD_LATCHED, 16'h0810);
    rd(`FLG_CMD_LATCHED, 16'h0810);
    wr(`FLG_CMD_FAULT_EN, 16'h3FEF);
    rd(`FLG_CMD_LATCHED, 16'h0800);
    wr(`FLG_CMD_PIN_CTRL, 16'h003A);
    rd(`FLG_CMD_PIN_CTRL, 16'h003A);
    cmp("alert drive", 16'h0000, {15'h0000, alertOeN});
    instFault = 14'h0000;
    rd(`FLG_CMD_LATCHED, 16'h0800);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp("alert drive", 16'h0001, {15'h0000, alertOeN});
    wr(`FLG_CMD_PIN_CTRL, 16'hFDFA);
    rd(`FLG_CMD_PIN_CTRL, 16'h01FA);
    cmp("result write test", 16'h0001, {15'h0000, hostResultWriteTest});
    // every mode of both pins with random faults, codes and pin levels
    for (int k = 0; k < 16; k++) begin
      f = ($urandom_range(1) == 1) ? 14'h0084 : 14'($urandom);
      dac0Code = ($urandom_range(1) == 1) ? 8'hFF : 8'h5A;
      dac1Code = ($urandom_range(1) == 1) ? 8'h00 : 8'hA5;
      ext0 = (k[1:0] == 2'h3) ? 1'($urandom_range(1)) : 1'b1;
      ext1 = (k[3:2] == 2'h3) ? 1'($urandom_range(1)) : 1'b1;
      instFault = f;
      w = (16'($urandom) & 16'h0030) | 16'h0080 | 16'(k);
      wr(`FLG_CMD_PIN_CTRL, w);
      pg = ~|(f & `FLG_VOLT_FAULT_MASK);
      df = dac0Code == `FLG_DAC_HIGH || dac1Code == `FLG_DAC_LOW;
      b0 = (k[1:0] == 2'h0) ? pg : (k[1:0] == 2'h1) ? ~pg : (k[1:0] == 2'h2) ? w[4] : ext0;
      b1 = (k[3:2] == 2'h0) ? df : (k[3:2] == 2'h1) ? ~df : (k[3:2] == 2'h2) ? w[5] : ext1;
      rd(`FLG_CMD_PIN_CTRL, {8'h00, 2'b11, b1, b0, w[3:0]});
      cmp("pin0 drive", 16'h0000, {15'h0000, gpio0OeN} ^ {15'h0000, (k[1:0] == 2'h3) | b0});
      cmp("pin1 drive", 16'h0000, {15'h0000, gpio1OeN} ^ {15'h0000, (k[3:2] == 2'h3) | b1});
    end
    instFault = 14'h0000;
    do_reset(1'b1);
    rd(`FLG_CMD_PIN_CTRL, 16'h02CA);
    cmp("pin0 drive", 16'h0000, {15'h0000, gpio0OeN});
    cmp("pin1 drive", 16'h0000, {15'h0000, gpio1OeN});
    rd(`FLG_CMD_MON_MASK, 16'h0000);
    repeat (3) @(posedge sys_clk);
    cmp("pending reads", 16'h0000, 16'(expQ.size()));
    giveVerdict();
  end
endmodule // testbench

bind flg_fault_latch_gpio_control flg_checker #(.TRACK_VARIANT(TRACK_VARIANT), .FAULT_COUNT(FAULT_COUNT),
  .MASK_COUNT(MASK_COUNT)) flg_checker_i (.sys_clk, .rstn, .cmdCode, .cmdWrite, .cmdRead, .cmdWriteData,
  .cmdReadData, .cmdReadValid, .gpio0Out, .gpio1Out, .alertIn, .alertOut, .strapIn, .monitorMask,
  .hostResultWriteTest, .trackStart);
